//--- shared/afs_defines.svh
// Purpose: offsets, field positions, reset values for the sample fifo block
// Assumes: register addresses are the device's internal 8-bit addresses
// Notes: status offset is a local choice of this block
`ifndef AFS_DEFINES_SVH
`define AFS_DEFINES_SVH
`define AFS_ADDR_LIMITS     8'h3C
`define AFS_ADDR_READ_PORT  8'h3D
`define AFS_ADDR_STATUS     8'h3E
`define AFS_LIMITS_RESET    24'hFFF000
`define AFS_UPPER_MSB       23
`define AFS_UPPER_LSB       12
`define AFS_LOWER_MSB       11
`define AFS_LOWER_LSB       0
`define AFS_ST_EMPTY        0
`define AFS_ST_WATERMARK    1
`define AFS_ST_OVERRUN      2
`define AFS_ST_LOWER_HIT    3
`define AFS_ST_UPPER_HIT    4
`define AFS_DEPTH           32
`define AFS_DATA_W          16
`endif

//--- shared/afs_pkg.sv
// Purpose: shared types for the sample fifo block
// Assumes: nothing beyond the defines header
// Notes: fifo mode selects the full-fifo policy
package afs_pkg;
	typedef enum logic {
		AFS_MODE_WATERMARK,
		AFS_MODE_STREAM
	} afs_mode_e;
endpackage

//--- design/afs_mem.sv
// Purpose: small storage array with registered read data
// Assumes: one write and one read port, same clock
// Notes: read data update on the cycle after the read enable
`timescale 1ns/1ns
module afs_mem #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic             MCLK,
	input  wire logic             WE,
	input  wire logic [AW-1:0]    WADDR,
	input  wire logic [WIDTH-1:0] WDATA,
	input  wire logic             RE,
	input  wire logic [AW-1:0]    RADDR,
	output logic      [WIDTH-1:0] RDATA
);
	logic [WIDTH-1:0] mem [DEPTH];

	// neither the storage nor the read register has a reset
	always_ff @(posedge MCLK) begin
		if (WE) begin
			mem[WADDR] <= WDATA;
		end
		if (RE) begin
			RDATA <= mem[RADDR];
		end
	end
endmodule // afs_mem

//--- design/afs_fifo.sv
// Purpose: first-in first-out buffer with valid/ready on both sides
// Assumes: synchronous active-low reset
// Notes: output data are registered; pop and push may share a cycle
`timescale 1ns/1ns
module afs_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic             MCLK,
	input  wire logic             RST_N,
	input  wire logic             FLUSH,
	input  wire logic             IN_VALID,
	output logic                  IN_READY,
	input  wire logic [WIDTH-1:0] IN_DATA,
	output logic                  OUT_VALID,
	input  wire logic             OUT_READY,
	output logic      [WIDTH-1:0] OUT_DATA,
	output logic      [AW:0]      COUNT
);
	typedef struct packed {
		logic [AW-1:0]    wp;
		logic [AW-1:0]    rp;
		logic [AW:0]      cnt;
		logic             byp;
		logic [WIDTH-1:0] byp_data;
	} afs_fifo_s;

	afs_fifo_s        st_r;
	afs_fifo_s        st_nxt;
	logic             push;
	logic             pop;
	logic [WIDTH-1:0] mem_rdata;

	assign IN_READY  = (st_r.cnt != (AW+1)'(DEPTH)) || pop;
	assign push      = IN_VALID && IN_READY && !FLUSH;
	assign pop       = OUT_READY && OUT_VALID && !FLUSH;
	assign OUT_VALID = (st_r.cnt != '0);
	assign COUNT     = st_r.cnt;
	// head word: bypass copy when the fetch raced its own write
	assign OUT_DATA  = st_r.byp ? st_r.byp_data : mem_rdata;

	// pointer and count update
	always_comb begin
		st_nxt = st_r;
		if (FLUSH) begin
			st_nxt = '0;
		end else begin
			if (push) begin
				st_nxt.wp = st_r.wp + AW'(1);
			end
			if (pop) begin
				st_nxt.rp = st_r.rp + AW'(1);
			end
			// the memory read register samples the old word when the
			// slot being fetched is written in the same cycle
			st_nxt.byp      = push && (st_r.wp == st_nxt.rp);
			st_nxt.byp_data = IN_DATA;
			st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// data at the head is fetched each cycle from the next read pointer
	afs_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_mem (
		.MCLK  (MCLK),
		.WE    (push),
		.WADDR (st_r.wp),
		.WDATA (IN_DATA),
		.RE    (1'b1),
		.RADDR (st_nxt.rp),
		.RDATA (mem_rdata)
	);
endmodule // afs_fifo

//--- design/afs_top.sv
// Purpose: conversion-result fifo with status flags and limit checks
// Assumes: host access is a one-cycle register read/write strobe
// Notes: entries carry a channel tag; limit enables apply per channel by RESULT_CHANNEL at store time
`timescale 1ns/1ns
`include "afs_defines.svh"

// Functional notes
// - watermark mode full: drop new, set overrun
// - stream mode full: drop oldest, store, overrun
// - overrun clears when fifo emptied
// - watermark flag equals count at least level
// - empty flag high when no entries
// - empty when enabled, drained, cleared, disabled
// - each flag drives its own interrupt
// - enabled channel result at/above upper sets flag
// - enabled channel result at/below lower sets flag
// - data port read returns 16-bit entry
// - limits register 24 bits, reset FFF000
// - limit flags clear when fifo emptied
module afs_top
	import afs_pkg::*;
#(
	parameter int DEPTH = `AFS_DEPTH,
	parameter int CH_W  = 4,
	parameter int NCH   = 16
) (
	input  wire logic        MCLK,
	input  wire logic        RST_N,
	input  wire logic        FIFO_ENABLE,
	input  wire afs_mode_e   FIFO_MODE,
	input  wire logic [$clog2(DEPTH):0] WATERMARK_LEVEL,
	input  wire logic        CLEAR_CMD,
	input  wire logic [NCH-1:0] CHANNEL_LIMIT_CHECK_ENABLE,
	input  wire logic        RESULT_VALID,
	input  wire logic [15:0] RESULT_DATA,
	input  wire logic [CH_W-1:0] RESULT_CHANNEL,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic [23:0] REG_WDATA,
	output logic      [23:0] REG_RDATA,
	output logic             OVERRUN_IRQ,
	output logic             WATERMARK_IRQ,
	output logic             EMPTY_IRQ,
	output logic             UPPER_LIMIT_IRQ,
	output logic             LOWER_LIMIT_IRQ
);
	localparam int AW = $clog2(DEPTH);
	localparam int W  = 16 + CH_W;

	typedef struct packed {
		logic [23:0] limits;
		logic        overrun;
		logic        upper_hit;
		logic        lower_hit;
		logic [23:0] rdata;
	} afs_top_s;

	afs_top_s       st_r;
	afs_top_s       st_nxt;
	logic           flush;
	logic           in_valid;
	logic           in_ready;
	logic           out_valid;
	logic           out_ready;
	logic [W-1:0]   out_data;
	logic [AW:0]    count;
	logic           full;
	logic           port_rd;
	logic           drop_old;
	logic           emptied;
	logic [11:0]    upper_limit_value;
	logic [11:0]    lower_limit_value;
	logic [7:0]     status;
	logic           empty_flag;
	logic           watermark_flag;
	logic           chk_en;

	assign upper_limit_value = st_r.limits[`AFS_UPPER_MSB:`AFS_UPPER_LSB];
	assign lower_limit_value = st_r.limits[`AFS_LOWER_MSB:`AFS_LOWER_LSB];

	// disabled or cleared fifo is flushed and reads empty
	assign flush = !FIFO_ENABLE || CLEAR_CMD;
	assign full  = (count == (AW+1)'(DEPTH));
	assign port_rd = REG_RD && (REG_ADDR == `AFS_ADDR_READ_PORT);
	// stream mode makes room by popping the oldest entry
	assign drop_old = RESULT_VALID && full && FIFO_ENABLE
		&& (FIFO_MODE == AFS_MODE_STREAM);
	assign out_ready = (port_rd || drop_old);
	// watermark mode: in_ready low at full unless a data port read pops, so new data is lost
	assign in_valid  = RESULT_VALID && FIFO_ENABLE;

	afs_fifo #(.WIDTH(W), .DEPTH(DEPTH)) u_fifo (
		.MCLK      (MCLK),
		.RST_N     (RST_N),
		.FLUSH     (flush),
		.IN_VALID  (in_valid),
		.IN_READY  (in_ready),
		.IN_DATA   ({RESULT_CHANNEL, RESULT_DATA}),
		.OUT_VALID (out_valid),
		.OUT_READY (out_ready),
		.OUT_DATA  (out_data),
		.COUNT     (count)
	);

	// flags derived straight from the count
	assign empty_flag     = (count == '0);
	assign watermark_flag = (count >= WATERMARK_LEVEL);
	// emptied: the last entry leaves, or a flush happens
	assign emptied = flush || (count == (AW+1)'(1) && port_rd
		&& !(in_valid && in_ready));
	assign chk_en = CHANNEL_LIMIT_CHECK_ENABLE[RESULT_CHANNEL];

	always_comb begin
		status = 8'h00;
		status[`AFS_ST_EMPTY]     = empty_flag;
		status[`AFS_ST_WATERMARK] = watermark_flag;
		status[`AFS_ST_OVERRUN]   = st_r.overrun;
		status[`AFS_ST_LOWER_HIT] = st_r.lower_hit;
		status[`AFS_ST_UPPER_HIT] = st_r.upper_hit;
	end

	// register writes, sticky flags and read data
	always_comb begin
		st_nxt = st_r;
		if (REG_WR && REG_ADDR == `AFS_ADDR_LIMITS) begin
			st_nxt.limits = REG_WDATA;
		end
		// emptying clears first; a new event in the same cycle wins
		if (emptied) begin
			st_nxt.overrun   = 1'b0;
			st_nxt.upper_hit = 1'b0;
			st_nxt.lower_hit = 1'b0;
		end
		// a data port read in the same cycle makes room: nothing lost
		if (RESULT_VALID && FIFO_ENABLE && !flush && full && !port_rd) begin
			st_nxt.overrun = 1'b1;
		end
		// check only results actually stored
		if (in_valid && in_ready && !flush && chk_en) begin
			if (RESULT_DATA[15:4] >= upper_limit_value) begin
				st_nxt.upper_hit = 1'b1;
			end
			if (RESULT_DATA[15:4] <= lower_limit_value) begin
				st_nxt.lower_hit = 1'b1;
			end
		end
		if (REG_RD) begin
			unique case (REG_ADDR)
				`AFS_ADDR_LIMITS:    st_nxt.rdata = st_r.limits;
				`AFS_ADDR_READ_PORT: st_nxt.rdata =
					{8'h00, out_valid ? out_data[15:0] : 16'h0000};
				`AFS_ADDR_STATUS:    st_nxt.rdata = {16'h0000, status};
				default:             st_nxt.rdata = 24'h000000;
			endcase
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			st_r.limits    <= `AFS_LIMITS_RESET;
			st_r.overrun   <= 1'b0;
			st_r.upper_hit <= 1'b0;
			st_r.lower_hit <= 1'b0;
			st_r.rdata     <= 24'h000000;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign REG_RDATA = st_r.rdata;
	// interrupts follow their flag bits in the same cycle
	assign OVERRUN_IRQ     = st_r.overrun;
	assign WATERMARK_IRQ   = watermark_flag;
	assign EMPTY_IRQ       = empty_flag;
	assign UPPER_LIMIT_IRQ = st_r.upper_hit;
	assign LOWER_LIMIT_IRQ = st_r.lower_hit;
endmodule // afs_top

//--- testbench/afs_checker.sv
// Purpose: port checks for the sample fifo top
// Assumes: one clock, sync active-low reset
// Notes: status read data reflect flags of the strobe cycle
`timescale 1ns/1ns
`include "afs_defines.svh"
module afs_checker (
	input wire logic        MCLK,
	input wire logic        RST_N,
	input wire logic        FIFO_ENABLE,
	input wire logic        CLEAR_CMD,
	input wire logic        RESULT_VALID,
	input wire logic        REG_RD,
	input wire logic [7:0]  REG_ADDR,
	input wire logic [23:0] REG_RDATA,
	input wire logic        OVERRUN_IRQ,
	input wire logic        WATERMARK_IRQ,
	input wire logic        EMPTY_IRQ,
	input wire logic        UPPER_LIMIT_IRQ,
	input wire logic        LOWER_LIMIT_IRQ
);
	logic [4:0] flags;
	// flag word in status bit order
	assign flags = {UPPER_LIMIT_IRQ, LOWER_LIMIT_IRQ, OVERRUN_IRQ,
		WATERMARK_IRQ, EMPTY_IRQ};
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	dis_empty_a: assert property (!FIFO_ENABLE |=> EMPTY_IRQ)
		else $error("empty low while disabled");
	clr_empty_a: assert property (CLEAR_CMD && !RESULT_VALID |=> EMPTY_IRQ)
		else $error("empty low after clear");
	fill_empty_a: assert property (FIFO_ENABLE && RESULT_VALID
		&& !CLEAR_CMD |=> !EMPTY_IRQ) else $error("empty high after store");
	sticky_clear_a: assert property (EMPTY_IRQ && !RESULT_VALID
		|=> !OVERRUN_IRQ && !UPPER_LIMIT_IRQ && !LOWER_LIMIT_IRQ)
		else $error("sticky flag kept on empty fifo");
	overrun_cause_a: assert property ($rose(OVERRUN_IRQ)
		|-> $past(RESULT_VALID) && !$past(EMPTY_IRQ))
		else $error("overrun without full store");
	upper_cause_a: assert property ($rose(UPPER_LIMIT_IRQ)
		|-> $past(RESULT_VALID)) else $error("upper hit without result");
	lower_cause_a: assert property ($rose(LOWER_LIMIT_IRQ)
		|-> $past(RESULT_VALID)) else $error("lower hit without result");
	status_bits_a: assert property (REG_RD && REG_ADDR == `AFS_ADDR_STATUS
		|=> REG_RDATA[4:0] == $past(flags)) else $error("status vs irq");
	port_upper_a: assert property (REG_RD && REG_ADDR == `AFS_ADDR_READ_PORT
		|=> REG_RDATA[23:16] == 8'h00) else $error("data port upper bits");
	rdata_hold_a: assert property (!REG_RD |=> $stable(REG_RDATA))
		else $error("read data moved without read");
endmodule // afs_checker
bind afs_top afs_checker chk (.MCLK(MCLK), .RST_N(RST_N),
	.FIFO_ENABLE(FIFO_ENABLE), .CLEAR_CMD(CLEAR_CMD),
	.RESULT_VALID(RESULT_VALID), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
	.REG_RDATA(REG_RDATA), .OVERRUN_IRQ(OVERRUN_IRQ),
	.WATERMARK_IRQ(WATERMARK_IRQ), .EMPTY_IRQ(EMPTY_IRQ),
	.UPPER_LIMIT_IRQ(UPPER_LIMIT_IRQ), .LOWER_LIMIT_IRQ(LOWER_LIMIT_IRQ));

//--- testbench/afs_host.sv
// Purpose: host model issuing register reads and writes
// Assumes: one-cycle strobes taken on the rising edge
// Notes: idle address and data invert so stale values never help
`timescale 1ns/1ns
module afs_host (
	input  wire logic        MCLK,
	input  wire logic [23:0] REG_RDATA,
	output logic             REG_WR,
	output logic             REG_RD,
	output logic      [7:0]  REG_ADDR,
	output logic      [23:0] REG_WDATA
);
	// idle bus at time zero
	initial begin
		REG_WR = 1'b0;
		REG_RD = 1'b0;
		REG_ADDR = 8'h00;
		REG_WDATA = 24'h000000;
	end
	// one access; read data taken one cycle after the strobe
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [23:0] d, output logic [23:0] q);
		@(posedge MCLK);
		#1;
		REG_WR = w;
		REG_RD = !w;
		REG_ADDR = a;
		REG_WDATA = d;
		@(posedge MCLK);
		#1;
		REG_WR = 1'b0;
		REG_RD = 1'b0;
		q = REG_RDATA;
		REG_ADDR = ~a;
		REG_WDATA = ~d;
	endtask
endmodule // afs_host

//--- testbench/tb.sv
// Purpose: directed tests of the sample fifo flags and ports
// Assumes: 125 MHz clock, sync reset held 12 cycles
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ns
`include "afs_defines.svh"
module tb;
	import afs_pkg::*;
	logic mclk = 1'b0, rst_n = 1'b0, en = 1'b1, clr = 1'b0, rv = 1'b0;
	afs_mode_e mode = AFS_MODE_WATERMARK;
	logic [5:0] wml = 6'h04;
	logic [15:0] lce = 16'h0008, rdat = 16'h0000;
	logic [3:0] rch = 4'h0;
	logic wr, rd, ovr, wm, emp, up, lo;
	logic [7:0] addr;
	logic [23:0] wdata, rdata, q;
	int fail_count = 0, tests_run = 0, i;
	// 8 ns clock
	always #4 mclk = ~mclk;
	afs_host host (.MCLK(mclk), .REG_RDATA(rdata), .REG_WR(wr),
		.REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata));
	afs_top uut (.MCLK(mclk), .RST_N(rst_n), .FIFO_ENABLE(en),
		.FIFO_MODE(mode), .WATERMARK_LEVEL(wml), .CLEAR_CMD(clr),
		.CHANNEL_LIMIT_CHECK_ENABLE(lce), .RESULT_VALID(rv),
		.RESULT_DATA(rdat), .RESULT_CHANNEL(rch), .REG_WR(wr), .REG_RD(rd),
		.REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
		.OVERRUN_IRQ(ovr), .WATERMARK_IRQ(wm), .EMPTY_IRQ(emp),
		.UPPER_LIMIT_IRQ(up), .LOWER_LIMIT_IRQ(lo));
	task automatic chk(input logic [23:0] g, input logic [23:0] e);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %0t data %h expected %h", $time, g, e);
		end
	endtask
	task automatic chkf(input logic g, input logic e);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %0t flag %b expected %b", $time, g, e);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [23:0] e);
		host.xfer(1'b0, a, 24'h000000, q);
		chk(q, e);
	endtask
	// one result pulse, then the data lines invert
	task automatic push(input logic [15:0] d, input logic [3:0] c);
		@(posedge mclk);
		#1;
		rv = 1'b1;
		rdat = d;
		rch = c;
		@(posedge mclk);
		#1;
		rv = 1'b0;
		rdat = ~d;
	endtask
	task automatic step();
		@(posedge mclk);
		#1;
	endtask
	task automatic conclude();
		$display("checks %0d failures %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (12) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		rdc(`AFS_ADDR_LIMITS, `AFS_LIMITS_RESET);
		rdc(`AFS_ADDR_STATUS, 24'h000001);
		rdc(`AFS_ADDR_READ_PORT, 24'h000000);
		rdc(8'h10, 24'h000000);
		host.xfer(1'b1, `AFS_ADDR_LIMITS, 24'h800200, q);
		rdc(`AFS_ADDR_LIMITS, 24'h800200);
		clr = 1'b1;
		step();
		clr = 1'b0;
		push(16'h8000, 4'h5);
		chkf(up, 1'b0);
		push(16'h2010, 4'h3);
		chkf(lo, 1'b0);
		push(16'h8000, 4'h3);
		chkf(up, 1'b1);
		chkf(wm, 1'b0);
		push(16'h200F, 4'h3);
		chkf(lo, 1'b1);
		chkf(wm, 1'b1);
		rdc(`AFS_ADDR_STATUS, 24'h00001A);
		rdc(`AFS_ADDR_READ_PORT, 24'h008000);
		chkf(wm, 1'b0);
		rdc(`AFS_ADDR_READ_PORT, 24'h002010);
		rdc(`AFS_ADDR_READ_PORT, 24'h008000);
		rdc(`AFS_ADDR_READ_PORT, 24'h00200F);
		step();
		chkf(up | lo, 1'b0);
		for (i = 0; i < 33; i++) push(16'(16'h0100 + i), 4'h0);
		chkf(ovr, 1'b1);
		for (i = 0; i < 32; i++) rdc(8'h3D, 24'(16'h0100 + i));
		step();
		chkf(ovr, 1'b0);
		mode = AFS_MODE_STREAM;
		for (i = 0; i < 33; i++) push(16'(16'h0200 + i), 4'h0);
		chkf(ovr, 1'b1);
		rdc(`AFS_ADDR_READ_PORT, 24'h000201);
		clr = 1'b1;
		step();
		clr = 1'b0;
		step();
		chkf(emp, 1'b1);
		chkf(ovr, 1'b0);
		push(16'h1234, 4'h0);
		chkf(emp, 1'b0);
		en = 1'b0;
		push(16'h4321, 4'h0);
		chkf(emp, 1'b1);
		en = 1'b1;
		step();
		chkf(emp, 1'b1);
		rdc(`AFS_ADDR_READ_PORT, 24'h000000);
		conclude();
	end
	// watchdog well beyond the expected run
	initial begin
		#100000;
		fail_count++;
		conclude();
	end
endmodule // tb
